/* core/vtc_pkg.sv */
// Purpose: Shared constants and carriers for the vertical table counter control.
// Assumes: One clock domain; registers reached over a plain strobe port.
// Notes:   Field positions follow the acquisition control word layout.
package vtc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] CMD_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Command register bit positions (write-only pulses)
  localparam int CMD_SWRESET_BIT = 0;
  localparam int CMD_ABORT_BIT = 1;
  localparam int CMD_CNTCLR_BIT = 2;

  // Status register bit positions
  localparam int STAT_PARKED_BIT = 16;
  localparam int STAT_HOLD_BIT = 17;
  localparam int STAT_TRIG_BIT = 18;
  localparam int STAT_FEN_BIT = 19;

  // Control word field positions (low bit of each field)
  localparam int RELEASE_LSB = 0;
  localparam int CLEAR_LSB = 3;
  localparam int LOAD_LSB = 6;
  localparam int STICK_LSB = 9;
  localparam int ABORT_LSB = 12;
  localparam int SKIPWAIT_BIT = 15;

  // ****************************************
  // Mode codes and counter values
  // ****************************************
  localparam logic [2:0] REL_NONE = 3'h0;
  localparam logic [2:0] REL_EDGE = 3'h1;
  localparam logic [2:0] REL_LEVEL = 3'h2;
  localparam logic [2:0] CLR_VAW = 3'h0;
  localparam logic [2:0] CLR_TRIG_VAW = 3'h1;
  localparam logic [2:0] CLR_TABLE = 3'h2;
  localparam logic [2:0] CLR_FEN = 3'h3;
  localparam logic [2:0] CLR_TRIG = 3'h4;
  localparam logic [2:0] LD_NONE = 3'h0;
  localparam logic [2:0] LD_FEN_QUAL = 3'h1;
  localparam logic [2:0] LD_FEN = 3'h2;
  localparam logic [2:0] LD_TRIG = 3'h3;
  localparam logic [2:0] STICK_ON = 3'h1;
  localparam logic [2:0] ABORT_TRIG = 3'h1;
  localparam logic [15:0] LOAD_VALUE = 16'h8000;
  localparam logic [15:0] STICK_ADDR = 16'h7ff0;

  // ****************************************
  // Carriers
  // ****************************************
  // Packed in control word order, bit 15 first
  typedef struct packed {
    logic skipWindowWait;
    logic [2:0] abortSourceSelect;
    logic [2:0] highStickMode;
    logic [2:0] counterPreloadMode;
    logic [2:0] counterClearMode;
    logic [2:0] zeroReleaseMode;
  } ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wrData;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } edge_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    edge_s out;
  } sync_state_s;

endpackage

/* core/pin_edge_sync.sv */
// Purpose: Three-stage synchroniser with edge pulses for one pin.
// Assumes: The pin is asynchronous to core_clk.
// Notes:   A change counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync
  import vtc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pin and result
  input wire logic pinIn,
  output vtc_pkg::edge_s edgeOut
);

  sync_state_s stateQ;
  sync_state_s stateD;

  // Next state: stage one is read only by stage two
  always_comb
  begin
    stateD = stateQ;
    stateD.s1 = pinIn;
    stateD.s2 = stateQ.s1;
    stateD.s3 = stateQ.s2;
    stateD.out.rise = 1'b0;
    stateD.out.fall = 1'b0;
    // Accept a new level only when the later stages agree
    if (stateQ.s2 == stateQ.s3 && stateQ.s3 != stateQ.out.level)
    begin
      stateD.out.level = stateQ.s3;
      stateD.out.rise = stateQ.s3;
      stateD.out.fall = ~stateQ.s3;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      stateQ <= '0;
    else
      stateQ <= stateD;
  end

  assign edgeOut = stateQ.out;

endmodule // pin_edge_sync
`default_nettype wire

/* core/vertical_table_counter_control.sv */
// Purpose: Vertical control table counter with its clear, preload and stick control.
// Assumes: Table columns, step and window inputs come from core_clk logic.
// Notes:   Trigger and frame enable are pins and pass a synchroniser.
//
// Behaviour
// - Release mode 000b never holds the counter at zero; 011b is reserved.
// - Release mode 001b holds zero until the trigger's leading edge.
// - Release mode 010b holds zero only while trigger low; rising edge releases.
// - Software reset, abort, counter clear bit or table clear column clear counter.
// - Clear mode 000b clears at window end or table clear column.
// - Clear mode 001b clears on trigger fall, window end or table clear column.
// - Clear mode 010b clears only on the table clear column.
// - Clear mode 011b clears on frame enable rise or table clear column.
// - Clear mode 100b clears on trigger fall or column, not window end.
// - Preload writes 8000h; preload mode 000b never loads.
// - Preload mode 001b loads on frame enable rise when qualifier set.
// - Preload mode 010b loads on every frame enable rise.
// - Preload mode 011b loads on every trigger rise.
// - High stick mode 1 parks at 7FF0h until load or clear.
// - Abort source 1 adds trigger fall to the host abort command.
// - Skip bit 0 makes head tag step wait for active window.
// - Control word fields sit at bits 2..0, 5..3, 8..6, 11..9, 14..12, 15.
`timescale 1ns/1ps
`default_nettype none
module vertical_table_counter_control
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [vtc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // External pins
  input wire logic triggerIn,
  input wire logic frameEnableInput,
  // Table and window inputs
  input wire logic counterStep,
  input wire logic tableClearColumn,
  input wire logic tableLoadQualifier,
  input wire logic verticalActiveWindow,
  input wire logic headTagReq,
  // Results
  output logic [15:0] verticalTableCounter,
  output logic abortAcq,
  output logic headTagGo
);
  import vtc_pkg::*;

  // ****************************************
  // State carrier
  // ****************************************
  typedef struct packed {
    ctrl_s ctrl;
    logic [15:0] cnt;
    logic armed;
    logic vawDly;
    logic swReset;
    logic cntClear;
    logic abortOut;
    logic [31:0] rdData;
  } vtc_state_s;

  vtc_state_s stateQ;
  vtc_state_s stateD;
  edge_s trig;
  edge_s fen;
  logic vawEnd;
  logic clearEv;
  logic loadEv;
  logic parked;
  logic holding;
  logic hostAbort;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // synchronous edge detect
  pin_edge_sync trigSync
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(triggerIn),
    .edgeOut(trig)
  );

  pin_edge_sync fenSync
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(frameEnableInput),
    .edgeOut(fen)
  );

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Mode-dependent clear sources; unused codes clear only by the column
  function automatic logic modeClear(input logic [2:0] mode, input logic vEnd,
                                     input edge_s t, input edge_s f);
    logic r;
    r = 1'b0;
    unique case (mode)
      CLR_VAW: r = vEnd;
      CLR_TRIG_VAW: r = t.fall | vEnd;
      CLR_TABLE: r = 1'b0;
      CLR_FEN: r = f.rise;
      CLR_TRIG: r = t.fall;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Preload sources
  function automatic logic modeLoad(input logic [2:0] mode, input logic qual,
                                    input edge_s t, input edge_s f);
    logic r;
    r = 1'b0;
    unique case (mode)
      LD_NONE: r = 1'b0;
      LD_FEN_QUAL: r = f.rise & qual;
      LD_FEN: r = f.rise;
      LD_TRIG: r = t.rise;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ****************************************
  // Event decoding
  // ****************************************
  // Window end is the falling edge of the active window
  assign vawEnd = stateQ.vawDly & ~verticalActiveWindow;
  assign hostAbort = regWr && regAddr == CMD_OFFSET && regWrData[CMD_ABORT_BIT];
  assign clearEv = stateQ.swReset | stateQ.abortOut | stateQ.cntClear | tableClearColumn
                   | modeClear(stateQ.ctrl.counterClearMode, vawEnd, trig, fen);
  assign loadEv = modeLoad(stateQ.ctrl.counterPreloadMode, tableLoadQualifier, trig, fen);
  assign parked = stateQ.ctrl.highStickMode == STICK_ON && stateQ.cnt == STICK_ADDR;

  // Zero hold; reserved release codes behave as no hold
  always_comb
  begin
    holding = 1'b0;
    if (stateQ.cnt == 16'h0000 && stateQ.armed && !trig.rise)
    begin
      if (stateQ.ctrl.zeroReleaseMode == REL_EDGE)
        holding = 1'b1;
      // level mode holds only while trigger low
      else if (stateQ.ctrl.zeroReleaseMode == REL_LEVEL)
        holding = ~trig.level;
      // mode 000b and reserved codes never hold
      else
        holding = 1'b0;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    stateD = stateQ;
    stateD.swReset = 1'b0;
    stateD.cntClear = 1'b0;
    stateD.rdData = '0;
    stateD.vawDly = verticalActiveWindow;
    // host abort always; trigger fall only when selected
    stateD.abortOut = hostAbort
                      | (stateQ.ctrl.abortSourceSelect == ABORT_TRIG && trig.fall);

    // Register writes; upper control bits belong to other blocks
    if (regWr)
    begin
      if (regAddr == CTRL_OFFSET)
        stateD.ctrl = ctrl_s'(regWrData[15:0]);
      else if (regAddr == CMD_OFFSET)
      begin
        stateD.swReset = regWrData[CMD_SWRESET_BIT];
        stateD.cntClear = regWrData[CMD_CNTCLR_BIT];
      end
    end

    // Register reads; unmapped addresses return zero
    if (regRd)
    begin
      if (regAddr == CTRL_OFFSET)
        stateD.rdData = {16'h0000, 16'(stateQ.ctrl)};
      else if (regAddr == STATUS_OFFSET)
      begin
        stateD.rdData[15:0] = stateQ.cnt;
        stateD.rdData[STAT_PARKED_BIT] = parked;
        stateD.rdData[STAT_HOLD_BIT] = holding;
        stateD.rdData[STAT_TRIG_BIT] = trig.level;
        stateD.rdData[STAT_FEN_BIT] = fen.level;
      end
    end

    // Counter priority: clear, load, park, hold, step
    // clear beats preload
    if (clearEv)
      stateD.cnt = 16'h0000;
    else if (loadEv)
      stateD.cnt = LOAD_VALUE;
    else if (parked || holding)
      stateD.cnt = stateQ.cnt;
    else if (counterStep)
      stateD.cnt = 16'(stateQ.cnt + 16'h0001);

    // Zero hold is armed by a clear and spent by a trigger rise
    if (clearEv)
      stateD.armed = 1'b1;
    else if (trig.rise)
      stateD.armed = 1'b0;
  end

  // State register; the hold starts armed so the first frame waits
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateQ <= '0;
      stateQ.ctrl <= ctrl_s'(CTRL_RESET);
      stateQ.armed <= 1'b1;
    end
    else
      stateQ <= stateD;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign regRdData = stateQ.rdData;
  assign verticalTableCounter = stateQ.cnt;
  assign abortAcq = stateQ.abortOut;
  // head tag waits for the window
  assign headTagGo = headTagReq & (stateQ.ctrl.skipWindowWait | verticalActiveWindow);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence anyFixedClear;
    stateQ.swReset || stateQ.abortOut || stateQ.cntClear || tableClearColumn;
  endsequence

  sequence plainStep;
    !clearEv && !loadEv && counterStep;
  endsequence

  // A step that no trigger rise can release in the same cycle
  sequence heldStep;
    !clearEv && !loadEv && counterStep && !trig.rise;
  endsequence

  fixed_clear_a: assert property (anyFixedClear |=> stateQ.cnt == 16'h0000)
    else $error("fixed clear source did not zero the counter");

  window_end_a: assert property ((stateQ.ctrl.counterClearMode == CLR_VAW
    || stateQ.ctrl.counterClearMode == CLR_TRIG_VAW) && vawEnd |=> stateQ.cnt == 16'h0000)
    else $error("window end did not clear counter");

  trig_fall_clear_a: assert property ((stateQ.ctrl.counterClearMode == CLR_TRIG
    || stateQ.ctrl.counterClearMode == CLR_TRIG_VAW) && trig.fall
    |=> stateQ.cnt == 16'h0000)
    else $error("trigger fall did not clear counter");

  fen_clear_a: assert property (stateQ.ctrl.counterClearMode == CLR_FEN && fen.rise
    |=> stateQ.cnt == 16'h0000)
    else $error("frame enable rise did not clear counter");

  preload_value_a: assert property (loadEv && !clearEv |=> stateQ.cnt == 16'h8000)
    else $error("preload did not write load value");

  qual_load_a: assert property (stateQ.ctrl.counterPreloadMode == LD_FEN_QUAL
    && fen.rise && !tableLoadQualifier && !clearEv && stateQ.cnt != 16'h7fff
    |=> stateQ.cnt != 16'h8000 || $past(stateQ.cnt) == 16'h8000)
    else $error("unqualified frame enable loaded counter");

  clear_wins_a: assert property (clearEv && loadEv |=> stateQ.cnt == 16'h0000)
    else $error("preload won over clear");

  park_hold_a: assert property (parked && !clearEv && !loadEv
    |=> stateQ.cnt == 16'h7ff0)
    else $error("counter left park address without load or clear");

  edge_hold_a: assert property (stateQ.ctrl.zeroReleaseMode == REL_EDGE
    && stateQ.armed && stateQ.cnt == 16'h0000 && !loadEv ##0 heldStep[*2]
    |=> stateQ.cnt == 16'h0000)
    else $error("edge mode released zero without trigger");

  no_hold_a: assert property (stateQ.ctrl.zeroReleaseMode == REL_NONE
    && stateQ.cnt == 16'h0000 ##0 plainStep |=> stateQ.cnt == 16'h0001)
    else $error("counter held at zero in normal mode");

  level_free_a: assert property (stateQ.ctrl.zeroReleaseMode == REL_LEVEL
    && stateQ.cnt == 16'h0000 && trig.level ##0 plainStep |=> stateQ.cnt == 16'h0001)
    else $error("level mode held zero with trigger high");

  level_hold_a: assert property (stateQ.ctrl.zeroReleaseMode == REL_LEVEL
    && stateQ.armed && stateQ.cnt == 16'h0000 && !trig.level ##0 heldStep
    |=> stateQ.cnt == 16'h0000)
    else $error("level mode left zero with trigger low");

  fen_load_a: assert property (stateQ.ctrl.counterPreloadMode == LD_FEN
    && fen.rise && !clearEv |=> stateQ.cnt == LOAD_VALUE)
    else $error("frame enable rise did not preload");

  trig_load_a: assert property (stateQ.ctrl.counterPreloadMode == LD_TRIG
    && trig.rise && !clearEv |=> stateQ.cnt == LOAD_VALUE)
    else $error("trigger rise did not preload");

  no_load_a: assert property (stateQ.ctrl.counterPreloadMode == LD_NONE
    && !clearEv && !counterStep |=> $stable(stateQ.cnt))
    else $error("counter moved with no load, clear or step");

  abort_src_a: assert property (!hostAbort
    && stateQ.ctrl.abortSourceSelect != ABORT_TRIG |=> !abortAcq)
    else $error("abort raised without selected source");

  trig_abort_a: assert property (stateQ.ctrl.abortSourceSelect == ABORT_TRIG
    && trig.fall |=> abortAcq)
    else $error("trigger fall did not abort");

  head_wait_a: assert property (headTagGo
    |-> stateQ.ctrl.skipWindowWait || verticalActiveWindow)
    else $error("head tag step ran outside active window");

endmodule // vertical_table_counter_control
`default_nettype wire

/* verif/trig_fen_source.sv */
// Purpose: Behavioural source of the trigger and frame enable pins.
// Assumes: Requests come from the bench in core_clk time.
// Notes:   Pins lag each request by a skew unrelated to the clock edge.
`timescale 1ns/1ps
`default_nettype none
module trig_fen_source
(
  // Requests from the bench
  input wire logic trigReq,
  input wire logic fenReq,
  // Pins toward the block
  output logic triggerIn,
  output logic frameEnableInput
);
  // Skew keeps pin changes off the sampling edge, as a real source would
  assign #7 triggerIn = trigReq;
  assign #7 frameEnableInput = fenReq;
endmodule // trig_fen_source
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for the vertical table counter control.
// Assumes: Pins come from the source model; table inputs are driven here.
// Notes:   Counter values are read back through the status register.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vtc_pkg::*;
  logic core_clk, rst_n, regWr, regRd, counterStep, tableClearColumn, rdSeen;
  logic tableLoadQualifier, verticalActiveWindow, headTagReq, trigReq, fenReq;
  logic triggerIn, frameEnableInput, abortAcq, headTagGo;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0] regWrData, regRdData, expQ[$], mskQ[$];
  logic [15:0] verticalTableCounter;
  logic [23:0] rows[14];
  int nErrors, checked, abortCnt, k;
  integer seed;

  // ****************************************
  // Clock, block and pin source
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  vertical_table_counter_control u_vertical_table_counter_control (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .triggerIn(triggerIn),
    .frameEnableInput(frameEnableInput), .counterStep(counterStep),
    .tableClearColumn(tableClearColumn), .tableLoadQualifier(tableLoadQualifier),
    .verticalActiveWindow(verticalActiveWindow), .headTagReq(headTagReq),
    .verticalTableCounter(verticalTableCounter), .abortAcq(abortAcq),
    .headTagGo(headTagGo));

  trig_fen_source u_trig_fen_source (.trigReq(trigReq), .fenReq(fenReq),
    .triggerIn(triggerIn), .frameEnableInput(frameEnableInput));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic closeOut();
    if (nErrors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // Expectation is queued now, compared when the data stands
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back(e);
    mskQ.push_back(m);
    @(posedge core_clk);
    regRd <= 1'b0;
  endtask

  task automatic expectCount(input logic [15:0] v);
    rd(STATUS_OFFSET, {16'h0000, v}, 32'h0000ffff);
  endtask

  task automatic step(input int n);
    @(posedge core_clk);
    counterStep <= 1'b1;
    repeat (n) @(posedge core_clk);
    counterStep <= 1'b0;
  endtask

  // Pin changes need the synchroniser delay before they act
  task automatic pulse(input logic [1:0] act);
    @(posedge core_clk);
    if (act == 2'h0)
      verticalActiveWindow <= 1'b1;
    else if (act == 2'h1)
      trigReq <= 1'b1;
    else
      fenReq <= 1'b1;
    repeat (6) @(posedge core_clk);
    {verticalActiveWindow, trigReq, fenReq} <= 3'h0;
    repeat (6) @(posedge core_clk);
  endtask

  // ****************************************
  // Result monitor and watchdog
  // ****************************************
  always @(posedge core_clk)
  begin
    rdSeen <= regRd;
    if (abortAcq === 1'b1)
      abortCnt++;
    if (rdSeen === 1'b1)
      check("regRdData", regRdData & mskQ.pop_front(), expQ.pop_front());
  end

  initial
  begin
    repeat (60000) @(posedge core_clk);
    nErrors++;
    closeOut();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 32'h2d6ae6ac;
    {rst_n, regWr, regRd, counterStep, tableClearColumn, tableLoadQualifier} = 6'h00;
    {verticalActiveWindow, headTagReq, trigReq, fenReq} = 4'h0;
    regAddr = '0;
    regWrData = 32'h0;
    // Row: control word, action (0 window, 1 trigger, 2 frame), qualifier*4 + result
    rows = '{24'h000001, 24'h000811, 24'h000801, 24'h001000, 24'h001010, 24'h001821,
             24'h002011, 24'h002000, 24'h001020, 24'h005020, 24'h005026, 24'h009022,
             24'h00d012, 24'h009821};
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(CTRL_OFFSET, {16'h0000, CTRL_RESET}, 32'hffffffff);
    rd(4'hc, 32'h0, 32'hffffffff);
    k = $random(seed);
    wr(CTRL_OFFSET, k);
    rd(CTRL_OFFSET, {16'h0000, k[15:0]}, 32'hffffffff);
    // Clear and preload sources per mode; result 0 keeps, 1 zero, 2 load value
    foreach (rows[i])
    begin
      wr(CTRL_OFFSET, {16'h0000, rows[i][23:8]});
      wr(CMD_OFFSET, 32'h1 << CMD_CNTCLR_BIT);
      k = ($random(seed) & 7) + 1;
      step(k);
      tableLoadQualifier <= rows[i][2];
      pulse(rows[i][5:4]);
      expectCount(rows[i][1:0] == 2'h0 ? k[15:0] : rows[i][1:0] == 2'h1 ? 16'h0 : LOAD_VALUE);
    end
    // Edge release holds zero until trigger rises
    wr(CTRL_OFFSET, 32'h0011);
    wr(CMD_OFFSET, 32'h1 << CMD_CNTCLR_BIT);
    step(3);
    expectCount(16'h0);
    trigReq <= 1'b1;
    repeat (6) @(posedge core_clk);
    step(3);
    expectCount(16'h3);
    // Level release: no hold while trigger high, hold while low
    wr(CTRL_OFFSET, 32'h0012);
    wr(CMD_OFFSET, 32'h1 << CMD_CNTCLR_BIT);
    step(2);
    expectCount(16'h2);
    trigReq <= 1'b0;
    repeat (6) @(posedge core_clk);
    wr(CMD_OFFSET, 32'h1 << CMD_CNTCLR_BIT);
    step(2);
    expectCount(16'h0);
    // Fixed clear sources: software reset, abort, clear bit, table column
    for (int b = 0; b < 4; b++)
    begin
      wr(CTRL_OFFSET, 32'h0010);
      step(4);
      if (b == 3)
        pulse(2'h3);
      if (b == 3)
        tableClearColumn <= 1'b1;
      else
        wr(CMD_OFFSET, 32'h1 << b);
      @(posedge core_clk);
      tableClearColumn <= 1'b0;
      expectCount(16'h0);
    end
    // Trigger fall aborts only with abort source 1
    wr(CTRL_OFFSET, 32'h1010);
    step(3);
    pulse(2'h1);
    expectCount(16'h0);
    check("abortCount", abortCnt, 32'h2);
    // Head tag waits for the window unless skipped
    for (int i = 0; i < 4; i++)
    begin
      wr(CTRL_OFFSET, i[1] ? 32'h8000 : 32'h0);
      verticalActiveWindow <= i[0];
      headTagReq <= 1'b1;
      repeat (2) @(posedge core_clk);
      check("headTagGo", {31'h0, headTagGo}, {31'h0, i[1] | i[0]});
    end
    verticalActiveWindow <= 1'b0;
    // Long run parks at the stick address; column releases it
    wr(CTRL_OFFSET, 32'h0210);
    wr(CMD_OFFSET, 32'h1 << CMD_CNTCLR_BIT);
    step(32760);
    rd(STATUS_OFFSET, {12'h000, 4'h1, STICK_ADDR}, 32'h000fffff);
    check("verticalTableCounter", 32'(verticalTableCounter), 32'(STICK_ADDR));
    @(posedge core_clk);
    tableClearColumn <= 1'b1;
    @(posedge core_clk);
    tableClearColumn <= 1'b0;
    expectCount(16'h0);
    repeat (4) @(posedge core_clk);
    closeOut();
  end
endmodule // tb
`default_nettype wire
